// [design/slink_codec.sv]
// Bi-phase mark frame transmitter and receiver with CRC
`timescale 1ns/1ns
module slink_codec (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Transmit request
  input  wire logic        tx_start,
  input  wire logic [7:0]  tx_id,
  input  wire logic [15:0] tx_data,
  output logic             tx_ready,
  // Received frame
  output logic             rx_valid,
  output logic [7:0]       rx_id,
  output logic [15:0]      rx_data,
  output logic             rx_crc_ok,
  output logic             carrier_ok,
  // Fibre
  output logic             line_out,
  input  wire logic        line_in
);
  logic [7:0]  hc_r, hc_nxt;
  logic        ph_r, ph_nxt, busy_r, busy_nxt, line_nxt, tick, cur;
  logic [5:0]  left_r, left_nxt;
  logic [42:0] sh_r, sh_nxt;
  logic        s1_r, s2_r, s3_r, pend_r, pend_nxt, rbusy_r, rbusy_nxt;
  logic        valid_nxt, ok_nxt, carrier_nxt, edge_seen, emit, bitv;
  logic [7:0]  ic_r, ic_nxt, id_nxt;
  logic [5:0]  rcnt_r, rcnt_nxt;
  logic [40:0] rsh_r, rsh_nxt;
  logic [15:0] data_nxt;

  assign tick     = hc_r == 8'(slink_pkg::HALF_CYC - 1);
  assign tx_ready = !busy_r && ph_r && !tick;
  assign cur      = busy_r ? sh_r[42] : 1'b1;

  // Transmit: toggle at every cell start, again mid cell for a one
  always_comb
  begin
    hc_nxt   = tick ? 8'h00 : hc_r + 8'h01;
    ph_nxt   = ph_r;
    busy_nxt = busy_r;
    left_nxt = left_r;
    sh_nxt   = sh_r;
    line_nxt = line_out;
    if (tx_start && tx_ready)
    begin
      sh_nxt   = {1'b0, tx_id, tx_data, slink_pkg::UNUSED_BYTE,
                  slink_pkg::crc8({slink_pkg::UNUSED_BYTE, tx_id, tx_data,
                                   slink_pkg::UNUSED_BYTE}),
                  slink_pkg::STOP_BITS};
      busy_nxt = 1'b1;
      left_nxt = 6'(slink_pkg::FRAME_BITS);
    end
    else if (tick)
    begin
      if (!ph_r)
      begin
        line_nxt = ~line_out;
        ph_nxt   = 1'b1;
      end
      else
      begin
        line_nxt = line_out ^ cur;
        ph_nxt   = 1'b0;
        if (busy_r)
        begin
          sh_nxt   = {sh_r[41:0], 1'b1};
          left_nxt = left_r - 6'h01;
          busy_nxt = left_r != 6'h01;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hc_r     <= 8'h00;
      ph_r     <= 1'b0;
      busy_r   <= 1'b0;
      left_r   <= 6'h00;
      sh_r     <= '0;
      line_out <= 1'b0;
    end
    else
    begin
      hc_r     <= hc_nxt;
      ph_r     <= ph_nxt;
      busy_r   <= busy_nxt;
      left_r   <= left_nxt;
      sh_r     <= sh_nxt;
      line_out <= line_nxt;
    end
  end

  // Receive: long gap is a zero, two short gaps a one
  assign edge_seen = s2_r ^ s3_r;

  always_comb
  begin
    ic_nxt      = edge_seen ? 8'h00 : ((ic_r == 8'hff) ? ic_r : ic_r + 8'h01);
    carrier_nxt = ic_r < 8'(slink_pkg::LOSS_CYC);
    pend_nxt    = pend_r;
    emit        = 1'b0;
    bitv        = 1'b0;
    rbusy_nxt   = rbusy_r;
    rcnt_nxt    = rcnt_r;
    rsh_nxt     = rsh_r;
    valid_nxt   = 1'b0;
    id_nxt      = rx_id;
    data_nxt    = rx_data;
    ok_nxt      = rx_crc_ok;
    if (edge_seen)
    begin
      if (ic_r >= 8'(slink_pkg::LONG_CYC - 1))
      begin
        emit     = 1'b1;
        pend_nxt = 1'b0;
      end
      else
      begin
        emit     = pend_r;
        bitv     = 1'b1;
        pend_nxt = !pend_r;
      end
    end
    // First edge after silence is no start bit
    if (emit && !rbusy_r && !bitv && carrier_ok)
    begin
      rbusy_nxt = 1'b1;
      rcnt_nxt  = 6'h00;
    end
    else if (emit && rbusy_r)
    begin
      rsh_nxt  = {rsh_r[39:0], bitv};
      rcnt_nxt = rcnt_r + 6'h01;
      if (rcnt_r == 6'(slink_pkg::FRAME_BITS - 2))
      begin
        rbusy_nxt = 1'b0;
        valid_nxt = 1'b1;
        id_nxt    = rsh_r[slink_pkg::RX_ID_LSB +: slink_pkg::ID_W];
        data_nxt  = rsh_r[slink_pkg::RX_DATA_LSB +: slink_pkg::DATA_W];
        ok_nxt    = (slink_pkg::crc8(rsh_r[40:1]) == 8'h00) && rsh_r[0] && bitv;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_r       <= 1'b0;
      s2_r       <= 1'b0;
      s3_r       <= 1'b0;
      ic_r       <= 8'hff;
      carrier_ok <= 1'b0;
      pend_r     <= 1'b0;
      rbusy_r    <= 1'b0;
      rcnt_r     <= 6'h00;
      rsh_r      <= '0;
      rx_valid   <= 1'b0;
      rx_id      <= 8'h00;
      rx_data    <= 16'h0000;
      rx_crc_ok  <= 1'b0;
    end
    else
    begin
      s1_r       <= line_in;
      s2_r       <= s1_r;
      s3_r       <= s2_r;
      ic_r       <= ic_nxt;
      carrier_ok <= carrier_nxt;
      pend_r     <= pend_nxt;
      rbusy_r    <= rbusy_nxt;
      rcnt_r     <= rcnt_nxt;
      rsh_r      <= rsh_nxt;
      rx_valid   <= valid_nxt;
      rx_id      <= id_nxt;
      rx_data    <= data_nxt;
      rx_crc_ok  <= ok_nxt;
    end
  end
endmodule

// [design/slink_if.sv]
// Fibre pair between controller board and supply interface unit
`timescale 1ns/1ns
interface slink_if;
  logic c2d;
  logic d2c;
  modport unit (input c2d, output d2c);
  modport ctrl (output c2d, input d2c);
endinterface

// [design/slink_pkg.sv]
// Shared constants, frame codes and helpers for the supply fibre link
package slink_pkg;
  // Clock and carrier timing
  localparam int CLK_HZ        = 100_000_000;
  localparam int CARRIER_HZ    = 5_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int HALF_CYC      = CLK_HZ / (2 * CARRIER_HZ);
  localparam int LONG_CYC      = (HALF_CYC * 3) / 2;
  localparam int LOSS_CYC      = HALF_CYC * 4;
  localparam int CONV_TIME_NS  = 20_000;
  localparam int CONV_CYC      = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_LAT      = 2;
  // Frame layout
  localparam int FRAME_BITS  = 43;
  localparam int ID_W        = 8;
  localparam int DATA_W      = 16;
  localparam int RX_ID_LSB   = 33;
  localparam int RX_DATA_LSB = 17;
  localparam logic [7:0] UNUSED_BYTE = 8'h00;
  localparam logic [1:0] STOP_BITS   = 2'h3;
  localparam logic [7:0] CRC_POLY    = 8'hb3;
  // Request codes
  localparam logic [7:0] ID_SET_NOREAD = 8'h55;
  localparam logic [7:0] ID_SET_READ   = 8'h15;
  localparam logic [7:0] ID_CMD_NOREAD = 8'h4a;
  localparam logic [7:0] ID_CMD_READ   = 8'h0a;
  localparam logic [7:0] ID_READ_CMD   = 8'h00;
  localparam logic [7:0] ID_READ_STAT  = 8'h40;
  // Reply codes
  localparam logic [7:0] ID_RSP_CMD  = 8'h95;
  localparam logic [7:0] ID_RSP_SET  = 8'h8a;
  localparam logic [7:0] ID_RSP_STAT = 8'h93;
  localparam logic [7:0] ID_RSP_ADC [4] = '{8'h80, 8'h90, 8'ha0, 8'hb0};
  // Reply lengths in frames, and index of the first converter frame
  localparam logic [2:0] LEN_NONE = 3'h0;
  localparam logic [2:0] LEN_ECHO = 3'h1;
  localparam logic [2:0] LEN_CMD  = 3'h3;
  localparam logic [2:0] LEN_STAT = 3'h6;
  localparam logic [2:0] IDX_FIRST_ADC = 3'h2;
  // Command word fields
  localparam int CMD_ACT_LSB = 14;
  localparam int CMD_REV_BIT = 13;
  localparam logic [1:0] ACT_ON      = 2'h3;
  localparam logic [1:0] ACT_OFF     = 2'h0;
  localparam logic [1:0] ACT_STANDBY = 2'h1;
  localparam logic [1:0] ACT_RESET   = 2'h2;
  // Controller registers (byte addresses)
  localparam logic [7:0] REG_REQ     = 8'h00;
  localparam logic [7:0] REG_GO      = 8'h04;
  localparam logic [7:0] REG_STATUS  = 8'h08;
  localparam logic [7:0] REG_RX_BASE = 8'h10;
  localparam int RX_WORDS     = 6;
  localparam int REQ_DATA_LSB = 16;
  localparam int RX_ERR_BIT   = 16;
  localparam int RX_ID_POS    = 24;
  localparam int ST_BUSY      = 0;
  localparam int ST_CRC_ERR   = 1;
  localparam int ST_CARRIER   = 2;
  localparam int ST_TIMEOUT   = 3;
  localparam int ST_COUNT_LSB = 8;

  // MSB first CRC; leading zero bits leave the result unchanged
  function automatic logic [7:0] crc8(input logic [39:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 39; i >= 0; i--)
    begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction

  // Frames expected in the reply to a request, none for an unknown code
  function automatic logic [2:0] reply_len(input logic [7:0] id);
    case (id)
      ID_SET_NOREAD, ID_CMD_NOREAD:            return LEN_ECHO;
      ID_READ_CMD:                             return LEN_CMD;
      ID_SET_READ, ID_CMD_READ, ID_READ_STAT: return LEN_STAT;
      default:                                 return LEN_NONE;
    endcase
  endfunction
endpackage

// [design/supply_controller_board.sv]
// Controller board end: APB registers, sends one request, gathers reply
`timescale 1ns/1ns
module supply_controller_board #(
  parameter int REPLY_TIMEOUT_CYC = 10000
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Fibre pair
  slink_if.ctrl            link
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_SEND = 3'b010,
    H_WAIT = 3'b100
  } ctrl_state_t;

  ctrl_state_t state_r, state_nxt;
  logic [7:0]  req_id_r, req_id_nxt, rx_id;
  logic [15:0] req_data_r, req_data_nxt, rx_data, tim_r, tim_nxt;
  logic [2:0]  cnt_r, cnt_nxt;
  logic [31:0] rx_r [slink_pkg::RX_WORDS];
  logic [31:0] rx_nxt [slink_pkg::RX_WORDS];
  logic [31:0] rd_nxt, status_w;
  logic        crc_err_r, crc_err_nxt, to_r, to_nxt, err_nxt, wr, setup;
  logic        tx_start, tx_ready, rx_valid, rx_crc_ok, carrier_ok;

  slink_codec codec (
    .pclk       (pclk),
    .presetn    (presetn),
    .tx_start   (tx_start),
    .tx_id      (req_id_r),
    .tx_data    (req_data_r),
    .tx_ready   (tx_ready),
    .rx_valid   (rx_valid),
    .rx_id      (rx_id),
    .rx_data    (rx_data),
    .rx_crc_ok  (rx_crc_ok),
    .carrier_ok (carrier_ok),
    .line_out   (link.c2d),
    .line_in    (link.d2c)
  );

  assign pready   = 1'b1;
  assign wr       = psel && penable && pwrite;
  assign setup    = psel && !penable;
  assign tx_start = (state_r == H_SEND) && tx_ready;
  assign status_w = {21'h0, cnt_r, 4'h0, to_r, carrier_ok, crc_err_r,
                     state_r != H_IDLE};

  // Read data and error latched in the setup cycle
  always_comb
  begin
    rd_nxt  = 32'h00000000;
    err_nxt = 1'b0;
    if (paddr == slink_pkg::REG_REQ)
    begin
      rd_nxt = {req_data_r, 8'h00, req_id_r};
    end
    else if (paddr == slink_pkg::REG_GO)
    begin
      rd_nxt = 32'h00000000;
    end
    else if (paddr == slink_pkg::REG_STATUS)
    begin
      rd_nxt = status_w;
    end
    else if (paddr >= slink_pkg::REG_RX_BASE && paddr[1:0] == 2'h0
             && paddr < slink_pkg::REG_RX_BASE + 8'(4 * slink_pkg::RX_WORDS))
    begin
      rd_nxt = rx_r[3'((paddr - slink_pkg::REG_RX_BASE) >> 2)];
    end
    else
    begin
      err_nxt = 1'b1;
    end
  end

  always_comb
  begin
    state_nxt    = state_r;
    req_id_nxt   = req_id_r;
    req_data_nxt = req_data_r;
    cnt_nxt      = cnt_r;
    tim_nxt      = tim_r;
    rx_nxt       = rx_r;
    crc_err_nxt  = crc_err_r;
    to_nxt       = to_r;
    if (wr && paddr == slink_pkg::REG_REQ && state_r == H_IDLE)
    begin
      req_id_nxt   = pwdata[7:0];
      req_data_nxt = pwdata[slink_pkg::REQ_DATA_LSB +: 16];
    end
    if (wr && paddr == slink_pkg::REG_STATUS)
    begin
      crc_err_nxt = crc_err_r && !pwdata[slink_pkg::ST_CRC_ERR];
      to_nxt      = to_r && !pwdata[slink_pkg::ST_TIMEOUT];
    end
    case (state_r)
      H_IDLE:
      begin
        if (wr && paddr == slink_pkg::REG_GO)
        begin
          state_nxt = H_SEND;
          cnt_nxt   = 3'h0;
          tim_nxt   = 16'h0000;
        end
      end
      H_SEND:
      begin
        if (tx_ready)
        begin
          state_nxt = H_WAIT;
        end
      end
      H_WAIT:
      begin
        tim_nxt = tim_r + 16'h0001;
        if (rx_valid)
        begin
          rx_nxt[cnt_r] = {rx_id, 7'h00, !rx_crc_ok, rx_data};
          cnt_nxt       = cnt_r + 3'h1;
          crc_err_nxt   = crc_err_nxt || !rx_crc_ok;
          if (cnt_r + 3'h1 >= slink_pkg::reply_len(req_id_r))
          begin
            state_nxt = H_IDLE;
          end
        end
        else if (tim_r == 16'(REPLY_TIMEOUT_CYC - 1))
        begin
          to_nxt    = 1'b1;
          state_nxt = H_IDLE;
        end
      end
      default:
      begin
        state_nxt = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r    <= H_IDLE;
      req_id_r   <= 8'h00;
      req_data_r <= 16'h0000;
      cnt_r      <= 3'h0;
      tim_r      <= 16'h0000;
      rx_r       <= '{default: 32'h00000000};
      crc_err_r  <= 1'b0;
      to_r       <= 1'b0;
      prdata     <= 32'h00000000;
      pslverr    <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      req_id_r   <= req_id_nxt;
      req_data_r <= req_data_nxt;
      cnt_r      <= cnt_nxt;
      tim_r      <= tim_nxt;
      rx_r       <= rx_nxt;
      crc_err_r  <= crc_err_nxt;
      to_r       <= to_nxt;
      if (setup)
      begin
        prdata  <= rd_nxt;
        pslverr <= err_nxt;
      end
    end
  end
endmodule

// [design/supply_interface_unit.sv]
// Supply interface unit end: decodes requests, drives supply, sends replies
// Operation
// - Bi-phase mark on continuous 5 MHz carrier
// - Idle line sends ones; zero starts frame
// - Start, id, data, zeros, CRC, two stops
// - CRC polynomial x8+x7+x5+x4+x+1 checked
// - Same frame layout in both directions
// - Controller opens exchange with one request
// - Code 55 loads setpoint, echo only
// - Code 15 loads setpoint, converts, full reading
// - Code 4A applies command, echo only
// - Code 0A applies command, converts, full reading
// - Code 00 returns echo, command, setpoint
// - Code 40 converts and returns full reading
// - Reading: echo, status, four converter results
// - Echo repeats request, always sent first
// - Conversion starts only on reading requests
// - Command bits 15:14 select supply action
// - Command bit 13 requests reverse polarity
// - Status bits 15:12 report supply state
// - Status bits 11:0 report fault flags
// - Wait conversion time before replying
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
module supply_interface_unit (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Fibre pair
  slink_if.unit            link,
  // Supply state pins
  input  wire logic        on_ind,
  input  wire logic        ctrl_off_ind,
  input  wire logic        standby_ind,
  input  wire logic        reverse_ind,
  input  wire logic [11:0] fault_ind,
  // Converters
  input  wire logic [15:0] adc_a,
  input  wire logic [15:0] adc_b,
  input  wire logic [15:0] adc_c,
  input  wire logic [15:0] adc_d,
  output logic             conv_start,
  output logic [15:0]      dac_value,
  // Command outputs
  output logic [15:0]      cmd_word,
  output logic             cmd_on,
  output logic             cmd_off,
  output logic             cmd_standby,
  output logic             cmd_reset,
  output logic             cmd_reverse,
  // Link health
  output logic             carrier_ok
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_CONV = 3'b010,
    S_SEND = 3'b100
  } unit_state_t;

  localparam logic [11:0] CONV_END = 12'(slink_pkg::CONV_CYC + slink_pkg::SYNC_LAT - 1);

  unit_state_t state_r, state_nxt;
  logic [79:0] sa_r, sb_r;
  logic [7:0]  req_id_r, req_id_nxt;
  logic [15:0] req_data_r, req_data_nxt;
  logic [2:0]  len_r, len_nxt, idx_r, idx_nxt, len_rx;
  logic [11:0] cnt_r, cnt_nxt;
  logic [15:0] status_r, status_nxt;
  logic [15:0] adc_r [4];
  logic [15:0] adc_nxt [4];
  logic [15:0] dac_nxt, cmd_nxt;
  logic        on_nxt, off_nxt, stb_nxt, rst_nxt, rev_nxt, conv_nxt;
  logic        tx_start, tx_ready, rx_valid, rx_crc_ok;
  logic [7:0]  rx_id, tx_id;
  logic [15:0] rx_data, tx_data;
  logic [1:0]  act;

  slink_codec codec (
    .pclk       (pclk),
    .presetn    (presetn),
    .tx_start   (tx_start),
    .tx_id      (tx_id),
    .tx_data    (tx_data),
    .tx_ready   (tx_ready),
    .rx_valid   (rx_valid),
    .rx_id      (rx_id),
    .rx_data    (rx_data),
    .rx_crc_ok  (rx_crc_ok),
    .carrier_ok (carrier_ok),
    .line_out   (link.d2c),
    .line_in    (link.c2d)
  );

  // Pins from the supply and converters are asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sa_r <= '0;
      sb_r <= '0;
    end
    else
    begin
      sa_r <= {on_ind, ctrl_off_ind, standby_ind, reverse_ind, fault_ind,
               adc_a, adc_b, adc_c, adc_d};
      sb_r <= sa_r;
    end
  end

  assign len_rx = slink_pkg::reply_len(rx_id);
  assign act    = rx_data[slink_pkg::CMD_ACT_LSB +: 2];

  // Reply frame selection
  always_comb
  begin
    tx_id   = req_id_r;
    tx_data = req_data_r;
    if (idx_r != 3'h0 && req_id_r == slink_pkg::ID_READ_CMD)
    begin
      tx_id   = (idx_r == 3'h1) ? slink_pkg::ID_RSP_CMD : slink_pkg::ID_RSP_SET;
      tx_data = (idx_r == 3'h1) ? cmd_word : dac_value;
    end
    else if (idx_r == 3'h1)
    begin
      tx_id   = slink_pkg::ID_RSP_STAT;
      tx_data = status_r;
    end
    else if (idx_r != 3'h0)
    begin
      tx_id   = slink_pkg::ID_RSP_ADC[2'(idx_r - slink_pkg::IDX_FIRST_ADC)];
      tx_data = adc_r[2'(idx_r - slink_pkg::IDX_FIRST_ADC)];
    end
  end

  assign tx_start = (state_r == S_SEND) && tx_ready;

  // Request handling and reply sequencing
  always_comb
  begin
    state_nxt    = state_r;
    req_id_nxt   = req_id_r;
    req_data_nxt = req_data_r;
    len_nxt      = len_r;
    idx_nxt      = idx_r;
    cnt_nxt      = cnt_r;
    status_nxt   = status_r;
    adc_nxt      = adc_r;
    dac_nxt      = dac_value;
    cmd_nxt      = cmd_word;
    on_nxt       = cmd_on;
    off_nxt      = cmd_off;
    stb_nxt      = cmd_standby;
    rst_nxt      = cmd_reset;
    rev_nxt      = cmd_reverse;
    conv_nxt     = 1'b0;
    case (state_r)
      S_IDLE:
      begin
        if (rx_valid && rx_crc_ok && len_rx != slink_pkg::LEN_NONE)
        begin
          req_id_nxt   = rx_id;
          req_data_nxt = rx_data;
          len_nxt      = len_rx;
          idx_nxt      = 3'h0;
          if (rx_id == slink_pkg::ID_SET_NOREAD || rx_id == slink_pkg::ID_SET_READ)
          begin
            dac_nxt = rx_data;
          end
          if (rx_id == slink_pkg::ID_CMD_NOREAD || rx_id == slink_pkg::ID_CMD_READ)
          begin
            cmd_nxt = rx_data;
            on_nxt  = act == slink_pkg::ACT_ON;
            off_nxt = act == slink_pkg::ACT_OFF;
            stb_nxt = act == slink_pkg::ACT_STANDBY;
            rst_nxt = act == slink_pkg::ACT_RESET;
            rev_nxt = rx_data[slink_pkg::CMD_REV_BIT];
          end
          if (len_rx == slink_pkg::LEN_STAT)
          begin
            conv_nxt  = 1'b1;
            cnt_nxt   = 12'h000;
            state_nxt = S_CONV;
          end
          else
          begin
            state_nxt = S_SEND;
          end
        end
      end
      S_CONV:
      begin
        cnt_nxt = cnt_r + 12'h001;
        if (cnt_r == CONV_END)
        begin
          status_nxt = sb_r[79:64];
          adc_nxt[0] = sb_r[63:48];
          adc_nxt[1] = sb_r[47:32];
          adc_nxt[2] = sb_r[31:16];
          adc_nxt[3] = sb_r[15:0];
          state_nxt  = S_SEND;
        end
      end
      S_SEND:
      begin
        if (tx_ready)
        begin
          idx_nxt = idx_r + 3'h1;
          if (idx_r == len_r - 3'h1)
          begin
            state_nxt = S_IDLE;
          end
        end
      end
      default:
      begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r     <= S_IDLE;
      req_id_r    <= 8'h00;
      req_data_r  <= 16'h0000;
      len_r       <= 3'h0;
      idx_r       <= 3'h0;
      cnt_r       <= 12'h000;
      status_r    <= 16'h0000;
      adc_r       <= '{default: 16'h0000};
      dac_value   <= 16'h0000;
      cmd_word    <= 16'h0000;
      cmd_on      <= 1'b0;
      cmd_off     <= 1'b0;
      cmd_standby <= 1'b0;
      cmd_reset   <= 1'b0;
      cmd_reverse <= 1'b0;
      conv_start  <= 1'b0;
    end
    else
    begin
      state_r     <= state_nxt;
      req_id_r    <= req_id_nxt;
      req_data_r  <= req_data_nxt;
      len_r       <= len_nxt;
      idx_r       <= idx_nxt;
      cnt_r       <= cnt_nxt;
      status_r    <= status_nxt;
      adc_r       <= adc_nxt;
      dac_value   <= dac_nxt;
      cmd_word    <= cmd_nxt;
      cmd_on      <= on_nxt;
      cmd_off     <= off_nxt;
      cmd_standby <= stb_nxt;
      cmd_reset   <= rst_nxt;
      cmd_reverse <= rev_nxt;
      conv_start  <= conv_nxt;
    end
  end
endmodule

// [tb/slink_chk.sv]
// Line checks on both fibres of the supply link
`timescale 1ns/1ns
module slink_chk (
  // Clock
  input wire logic pclk,
  input wire logic presetn,
  // Fibres
  input wire logic c2d,
  input wire logic d2c
);
  logic [1:0] ln, pv_r, go_r, lz_r, ph_r;
  logic [4:0] n_r [2];
  logic [5:0] z_r [2];
  assign ln = {d2c, c2d};
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pv_r <= 2'h0;
      go_r <= 2'h0;
      lz_r <= 2'h0;
      ph_r <= 2'h0;
      n_r <= '{5'h0, 5'h0};
      z_r <= '{6'h0, 6'h0};
    end
    else
    begin
      pv_r <= ln;
      for (int i = 0; i < 2; i++)
        if (ln[i] != pv_r[i])
        begin
          go_r[i] <= 1'b1;
          n_r[i] <= 5'h0;
          ph_r[i] <= (n_r[i] == 5'h9) ? !ph_r[i] : 1'b0;
          lz_r[i] <= lz_r[i] | (go_r[i] & (n_r[i] == 5'h13));
          z_r[i] <= (n_r[i] == 5'h13) ? z_r[i] + 6'h1 : 6'h0;
        end
        else if (n_r[i] != 5'h1f)
          n_r[i] <= n_r[i] + 5'h1;
    end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence c_edge; go_r[0] && c2d != pv_r[0]; endsequence
  sequence d_edge; go_r[1] && d2c != pv_r[1]; endsequence
  a_c2d_run: assert property (c_edge |-> n_r[0] inside {5'h9, 5'h13})
    else $error("c2d run");
  a_d2c_run: assert property (d_edge |-> n_r[1] inside {5'h9, 5'h13})
    else $error("d2c run");
  a_c2d_still: assert property (go_r[0] |-> n_r[0] < 5'h14)
    else $error("c2d still");
  a_d2c_still: assert property (go_r[1] |-> n_r[1] < 5'h14)
    else $error("d2c still");
  a_c2d_cell: assert property (c_edge ##0 (lz_r[0] && n_r[0] == 5'h13) |-> !ph_r[0])
    else $error("c2d cell");
  a_d2c_cell: assert property (d_edge ##0 (lz_r[1] && n_r[1] == 5'h13) |-> !ph_r[1])
    else $error("d2c cell");
  a_c2d_zeros: assert property (z_r[0] <= 6'h29)
    else $error("c2d zeros");
  a_d2c_zeros: assert property (z_r[1] <= 6'h29)
    else $error("d2c zeros");
endmodule

// [tb/test_supply_link_frame_protocol.sv]
// Bench joining controller board and interface unit
`timescale 1ns/1ns
module test_supply_link_frame_protocol;
  logic pclk, presetn, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, q;
  logic [3:0] st;
  logic [11:0] flt;
  logic [15:0] adc [4];
  logic [15:0] v;
  wire pready, pslverr, cv, c_ok;
  wire [31:0] prdata;
  wire [15:0] dac, cw;
  wire [4:0] co;
  int mismatches = 0, n_tests = 0, n_conv = 0, c;
  slink_if slink_if_i ();
  slink_chk slink_chk_i (.pclk(pclk), .presetn(presetn), .c2d(slink_if_i.c2d),
    .d2c(slink_if_i.d2c));
  supply_interface_unit supply_interface_unit_i (.pclk(pclk), .presetn(presetn),
    .link(slink_if_i.unit), .on_ind(st[3]), .ctrl_off_ind(st[2]), .standby_ind(st[1]),
    .reverse_ind(st[0]), .fault_ind(flt), .adc_a(adc[0]), .adc_b(adc[1]), .adc_c(adc[2]),
    .adc_d(adc[3]), .conv_start(cv), .dac_value(dac), .cmd_word(cw), .cmd_on(co[4]),
    .cmd_off(co[3]), .cmd_standby(co[2]), .cmd_reset(co[1]), .cmd_reverse(co[0]),
    .carrier_ok(c_ok));
  supply_controller_board #(.REPLY_TIMEOUT_CYC(9000)) supply_controller_board_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(slink_if_i.ctrl));
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk)
    if (cv === 1'b1)
      n_conv <= n_conv + 1;
  task automatic summarize();
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic tmo(inout int t, input int lim);
    t++;
    if (t > lim)
    begin
      mismatches++;
      summarize();
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      tmo(t, 50);
      @(posedge pclk);
    end
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic go(input logic [7:0] id, input logic [15:0] d);
    apb(1'b1, slink_pkg::REG_REQ, {d, 8'h0, id});
    apb(1'b1, slink_pkg::REG_GO, 32'h1);
  endtask
  task automatic fin(input logic [7:0] id, input logic [15:0] d, input logic [2:0] n);
    int t;
    t = 0;
    q = 32'h1;
    while (q[0] !== 1'b0)
    begin
      tmo(t, 4000);
      apb(1'b0, slink_pkg::REG_STATUS, 32'h0);
    end
    chk(q[10:8], n);
    chk({c_ok, q[2:1]}, 3'h6);
    if (n != 3'h0)
    begin
      apb(1'b0, slink_pkg::REG_RX_BASE, 32'h0);
      chk(q, {id, 8'h0, d});
    end
  endtask
  task automatic rd(input logic [7:0] id, input logic [15:0] d);
    int t;
    t = 0;
    c = n_conv;
    go(id, d);
    while (n_conv == c)
    begin
      tmo(t, 2000);
      @(posedge pclk);
    end
    repeat (1900) @(posedge pclk);
    apb(1'b0, slink_pkg::REG_STATUS, 32'h0);
    chk(q[10:8], 3'h0);
    fin(id, d, slink_pkg::LEN_STAT);
    chk(n_conv, c + 1);
    apb(1'b0, slink_pkg::REG_RX_BASE + 8'h4, 32'h0);
    chk(q, {slink_pkg::ID_RSP_STAT, 8'h0, st, flt});
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, slink_pkg::REG_RX_BASE + 8'h8 + 8'(4 * i), 32'h0);
      chk(q, {slink_pkg::ID_RSP_ADC[i], 8'h0, adc[i]});
    end
  endtask
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = 43'h0;
    st = 4'ha;
    flt = 12'h5a3;
    adc = '{16'h8001, 16'h7fff, 16'h0000, 16'hffff};
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (1000) @(posedge pclk);
    apb(1'b0, 8'h3c, 32'h0);
    chk({31'h0, pslverr}, 32'h1);
    chk(q, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      v = {i[1:0], i[0], 13'h1555};
      go(slink_pkg::ID_CMD_NOREAD, v);
      fin(slink_pkg::ID_CMD_NOREAD, v, 3'h1);
      chk({co, cw}, {i == 3, i == 0, i == 1, i == 2, i[0], v});
    end
    go(slink_pkg::ID_SET_NOREAD, 16'h8123);
    fin(slink_pkg::ID_SET_NOREAD, 16'h8123, 3'h1);
    chk(dac, 16'h8123);
    go(slink_pkg::ID_READ_CMD, 16'h0);
    fin(slink_pkg::ID_READ_CMD, 16'h0, 3'h3);
    apb(1'b0, slink_pkg::REG_RX_BASE + 8'h4, 32'h0);
    chk(q, {slink_pkg::ID_RSP_CMD, 8'h0, 16'hf555});
    apb(1'b0, slink_pkg::REG_RX_BASE + 8'h8, 32'h0);
    chk(q, {slink_pkg::ID_RSP_SET, 8'h0, 16'h8123});
    chk(n_conv, 0);
    rd(slink_pkg::ID_SET_READ, 16'h1234);
    chk(dac, 16'h1234);
    st <= 4'h5;
    flt <= 12'ha5c;
    rd(slink_pkg::ID_CMD_READ, 16'h4000);
    chk(co, 5'h04);
    rd(slink_pkg::ID_READ_STAT, 16'h0);
    chk(cw, 16'h4000);
    go(8'h33, 16'h0);
    fin(8'h33, 16'h0, 3'h0);
    chk({q[3], cw, dac}, {1'b1, 16'h4000, 16'h1234});
    apb(1'b1, slink_pkg::REG_STATUS, 32'ha);
    apb(1'b0, slink_pkg::REG_STATUS, 32'h0);
    chk(q[3:0], 4'h4);
    summarize();
  end
endmodule
